// ===== flash_guard_defines.svh
/*
 Constants for the serial flash front end: opcodes, status bit positions,
 power-up write delay and the fixed busy times of the modifying operations.
 Assumes a 100 MHz system clock; included by the guard module and the bench.
*/
// Contract
// - Single lane input sampled on rising clock
// - Single lane output changes on falling clock
// - Modes 0 and 3 accepted
// - Dual reads use both lanes, two bits
// - Pause starts now if clock low, else
// - Pause ends now if clock low, else
// - Paused: output off, inputs ignored, state kept
// - Reset below threshold; then power-up write delay
// - Write latch clear after power-up
// - Modifying instructions need write latch set
// - Write latch bit1, set/cleared by instructions
// - Power-down ignores all but release
// - Busy bit0, blocks all but status read
// - Region guard bits 3:2, reset zero
// - Lock plus low guard pin refuses writes
// - Low-end bit 5, default zero, needs enable
// - Bits 6 and 4 read zero
// - Lock bit 7 gates guard pin effect
// - Program/erase into protected region ignored
// - Opcode first, msb first, rising edges
// - Modifying instructions end on byte boundary
`ifndef FLASH_GUARD_DEFINES_SVH
`define FLASH_GUARD_DEFINES_SVH
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RDSR 8'h05
`define OP_WRSR 8'h01
`define OP_READ 8'h03
`define OP_FAST 8'h0B
`define OP_DUAL_OUT 8'h3B
`define OP_DUAL_IO 8'hBB
`define OP_PROG 8'h02
`define OP_SE 8'h20
`define OP_BE32 8'h52
`define OP_BE64 8'hD8
`define OP_CE1 8'hC7
`define OP_CE2 8'h60
`define OP_PD 8'hB9
`define OP_RPD 8'hAB
`define ST_BUSY 0
`define ST_WL 1
`define ST_GLO 2
`define ST_GHI 3
`define ST_RSV4 4
`define ST_LOW 5
`define ST_RSV6 6
`define ST_LOCK 7
`define STATUS_RESET 8'h00
`define PUW_US 5
`define PUW_CYC ((`PUW_US * 100 + 0) )
`define BUSY_CYC 16'h0400
`define MODIFY_BUSY_CYC 16'h0400
`endif

// ===== flash_guard_pkg.sv
/*
 Types shared by the flash front end modules.
 Assumes the defines header is available on the include path.
*/
package flash_guard_pkg;
	// Transfer phases of one selected frame
	typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DATA_IN, PH_READ_OUT, PH_IGNORE} phase_t;
endpackage

// ===== pin_sync.sv
/*
 Three-stage input synchroniser with agreement filter.
 Assumes an asynchronous pin; output changes once stages two and three agree.
*/
`timescale 1ns/1ns
module pin_sync #(parameter logic INIT = 1'b0) (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic pin, // Raw pin
	output logic q // Filtered level
);
	logic s1_r; // Metastability stage, read by s2 only
	logic s2_r; // Second stage
	logic s3_r; // Third stage

	// Shift chain
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Accept a change only when two stable stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= INIT;
		end else if (s2_r == s3_r) begin
			q <= s3_r;
		end
	end
endmodule

// ===== flash_spi_guard.sv
/*
 Serial flash slave front end: SPI framing, pause, write latch, busy,
 status register and write guarding. Array datapath is outside.
 Assumes the link pins are sampled by clk, which is far faster than sck.
*/
`timescale 1ns/1ns
`include "flash_guard_defines.svh"
module flash_spi_guard #(parameter int PUW_CYCLES = 500) (
	input wire logic clk, // 100 MHz system clock
	input wire logic rst, // Power-on reset, high below threshold
	input wire logic sck, // Serial clock from master
	input wire logic cs_n, // Chip select, active low
	input wire logic pause_n, // Pause input, active low
	input wire logic guard_n, // Write guard input, active low
	input wire logic lane0_i, // Lane 0 / serial_in level
	output logic lane0_o, // Lane 0 drive value
	output logic lane0_oe_n, // Lane 0 enable, low drives
	input wire logic lane1_i, // Lane 1 level
	output logic lane1_o, // Lane 1 drive value
	output logic lane1_oe_n, // Lane 1 enable, low drives
	output logic [7:0] status_out, // Status register image
	output logic powered_down // Power-down state
);
	import flash_guard_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Synchronised pins
	logic sck_s, cs_n_s, pause_n_s, guard_n_s, l0_s, l1_s; // Filtered levels
	pin_sync #(.INIT(1'b0)) u_sck (.clk(clk), .rst(rst), .pin(sck), .q(sck_s));
	pin_sync #(.INIT(1'b1)) u_cs (.clk(clk), .rst(rst), .pin(cs_n), .q(cs_n_s));
	pin_sync #(.INIT(1'b1)) u_ps (.clk(clk), .rst(rst), .pin(pause_n), .q(pause_n_s));
	pin_sync #(.INIT(1'b1)) u_gd (.clk(clk), .rst(rst), .pin(guard_n), .q(guard_n_s));
	pin_sync #(.INIT(1'b0)) u_l0 (.clk(clk), .rst(rst), .pin(lane0_i), .q(l0_s));
	pin_sync #(.INIT(1'b0)) u_l1 (.clk(clk), .rst(rst), .pin(lane1_i), .q(l1_s));

	logic sck_d_r; // Previous clock level
	logic cs_d_r; // Previous select level
	logic paused_r; // Pause condition active
	logic rise, fall, cs_fall, cs_rise; // Edge strobes

	// Edge history
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end else begin
			sck_d_r <= sck_s;
			cs_d_r <= cs_n_s;
		end
	end
	// Edges only count while selected and not paused; mode 3 idle-high clock gives no edge at select
	assign rise = sck_s & ~sck_d_r & ~cs_n_s & ~paused_r;
	assign fall = ~sck_s & sck_d_r & ~cs_n_s & ~paused_r;
	assign cs_fall = ~cs_n_s & cs_d_r;
	assign cs_rise = cs_n_s & ~cs_d_r;

	////////////////////////////////////////////////////////////////////////
	// Pause control
	logic pause_want; // Requested pause level
	assign pause_want = ~pause_n_s;
	// Change applies at once with clock low, else at next falling edge
	always_ff @(posedge clk) begin
		if (rst || cs_n_s) begin
			paused_r <= 1'b0;
		end else if (pause_want != paused_r) begin
			if (!sck_s) begin
				paused_r <= pause_want;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-up write delay
	logic [15:0] puw_cnt_r; // Counts down after reset release
	logic puw_done; // Delay expired
	always_ff @(posedge clk) begin
		if (rst) begin
			puw_cnt_r <= 16'(PUW_CYCLES);
		end else if (puw_cnt_r != 16'h0000) begin
			puw_cnt_r <= puw_cnt_r - 16'h0001;
		end
	end
	assign puw_done = (puw_cnt_r == 16'h0000);

	////////////////////////////////////////////////////////////////////////
	// Frame shifter
	phase_t phase_r; // Frame phase
	logic [7:0] sh_r; // Input shift register
	logic [2:0] bit_r; // Bit counter in byte
	logic [7:0] op_r; // Latched opcode
	logic [7:0] wdata_r; // Last status write byte
	logic byte_done; // Whole byte just completed
	logic [4:0] bytes_r; // Bytes seen after opcode
	logic dual_r; // Two-bit lanes active
	logic [2:0] step; // Bits taken per rising edge
	assign step = dual_r ? 3'h2 : 3'h1;
	logic [3:0] bit_sum; // Bit position after this edge, carry kept
	assign bit_sum = {1'b0, bit_r} + {1'b0, step};
	assign byte_done = rise && (bit_sum == 4'h8);

	logic busy_r; // Modify in progress
	logic pd_r; // Powered down
	logic [7:0] st_r; // Stored status bits

	// Input sampling on rising edges, msb first
	always_ff @(posedge clk) begin
		if (rst || cs_n_s) begin
			sh_r <= 8'h00;
			bit_r <= 3'h0;
			op_r <= 8'h00;
			bytes_r <= 5'h00;
			phase_r <= PH_OPCODE;
			dual_r <= 1'b0;
		end else if (rise) begin
			if (dual_r && phase_r != PH_READ_OUT) begin
				sh_r <= {sh_r[5:0], l1_s, l0_s};
			end else begin
				sh_r <= {sh_r[6:0], l0_s};
			end
			bit_r <= bit_r + step;
			if (byte_done) begin
				if (phase_r == PH_OPCODE) begin
					op_r <= {sh_r[6:0], l0_s};
					phase_r <= PH_ADDR;
					dual_r <= ({sh_r[6:0], l0_s} == `OP_DUAL_IO);
				end else if (bytes_r != 5'h1F) begin
					bytes_r <= bytes_r + 5'h01;
				end
				if (op_r == `OP_DUAL_OUT && bytes_r == 5'h03) begin
					dual_r <= 1'b1;
				end
			end
		end
	end

	// Status byte captured for a write
	always_ff @(posedge clk) begin
		if (rst) begin
			wdata_r <= 8'h00;
		end else if (byte_done && phase_r == PH_ADDR && op_r == `OP_WRSR && bytes_r == 5'h00) begin
			wdata_r <= {sh_r[6:0], l0_s};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Instruction execution at select rise
	logic gate_ok; // Instruction may be acted on
	logic on_byte; // Frame ended on byte boundary
	logic is_mod; // Modifying opcode
	logic status_locked; // Lock bit and guard pin low
	logic region_prot; // Any guard bit set
	logic [15:0] busy_cnt_r; // Busy time counter
	assign on_byte = (bit_r == 3'h0);
	assign gate_ok = !busy_r && puw_done && (!pd_r || op_r == `OP_RPD);
	assign is_mod = op_r == `OP_PROG || op_r == `OP_SE || op_r == `OP_BE32 || op_r == `OP_BE64 ||
		op_r == `OP_CE1 || op_r == `OP_CE2;
	assign status_locked = st_r[`ST_LOCK] & ~guard_n_s;
	assign region_prot = st_r[`ST_GHI] | st_r[`ST_GLO];

	// Write latch, busy, power-down and stored status
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= `STATUS_RESET;
			busy_r <= 1'b0;
			pd_r <= 1'b0;
			busy_cnt_r <= 16'h0000;
		end else begin
			if (busy_r) begin
				if (busy_cnt_r == 16'h0001) begin
					busy_r <= 1'b0;
					st_r[`ST_WL] <= 1'b0;
				end
				busy_cnt_r <= busy_cnt_r - 16'h0001;
			end
			if (cs_rise && phase_r != PH_OPCODE && gate_ok && on_byte) begin
				if (op_r == `OP_WREN) begin
					st_r[`ST_WL] <= 1'b1;
				end else if (op_r == `OP_WRDI) begin
					st_r[`ST_WL] <= 1'b0;
				end else if (op_r == `OP_PD) begin
					pd_r <= 1'b1;
				end else if (op_r == `OP_RPD) begin
					pd_r <= 1'b0;
				end else if (op_r == `OP_WRSR && st_r[`ST_WL] && bytes_r != 5'h00) begin
					busy_r <= 1'b1;
					busy_cnt_r <= `MODIFY_BUSY_CYC;
					if (!status_locked) begin
						st_r[`ST_LOCK] <= wdata_r[`ST_LOCK];
						st_r[`ST_LOW] <= wdata_r[`ST_LOW];
						st_r[`ST_GHI] <= wdata_r[`ST_GHI];
						st_r[`ST_GLO] <= wdata_r[`ST_GLO];
					end
				end else if (is_mod && st_r[`ST_WL] && !region_prot) begin
					busy_r <= 1'b1;
					busy_cnt_r <= `MODIFY_BUSY_CYC;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read output on falling edges
	logic [7:0] st_view; // Status as read
	logic rd_active; // Frame reads status
	assign st_view = {st_r[`ST_LOCK], 1'b0, st_r[`ST_LOW], 1'b0, st_r[`ST_GHI], st_r[`ST_GLO],
		st_r[`ST_WL], busy_r};
	assign rd_active = op_r == `OP_RDSR && phase_r == PH_ADDR && (!pd_r);
	logic [7:0] out_sh_r; // Output shifter
	logic out_on_r; // Lane 1 has started driving in this frame
	// Enable drops in a pause and returns after it, so the held bit is shown again before the next edge
	always_ff @(posedge clk) begin
		if (rst || cs_n_s) begin
			out_sh_r <= 8'h00;
			out_on_r <= 1'b0;
			lane1_o <= 1'b0;
			lane1_oe_n <= 1'b1;
			lane0_o <= 1'b0;
			lane0_oe_n <= 1'b1;
		end else if (paused_r) begin
			lane1_oe_n <= 1'b1;
			lane0_oe_n <= 1'b1;
		end else if (fall && rd_active) begin
			// Status repeats every byte while select stays low
			if (bit_r == 3'h0) begin
				lane1_o <= st_view[7];
				out_sh_r <= {st_view[6:0], 1'b0};
			end else begin
				lane1_o <= out_sh_r[7];
				out_sh_r <= {out_sh_r[6:0], 1'b0};
			end
			lane1_oe_n <= 1'b0;
			out_on_r <= 1'b1;
		end else if (out_on_r) begin
			lane1_oe_n <= 1'b0;
		end
	end

	// Visible state
	always_ff @(posedge clk) begin
		if (rst) begin
			status_out <= `STATUS_RESET;
			powered_down <= 1'b0;
		end else begin
			status_out <= st_view;
			powered_down <= pd_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	busy_blocks_a: assert property (@(posedge clk) disable iff (rst)
		busy_r && cs_rise && op_r == `OP_WREN |=> !$rose(st_r[`ST_WL]))
		else $error("write enable taken while busy");
	reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
		status_out[6] == 1'b0 && status_out[4] == 1'b0)
		else $error("reserved status bit set");
	puw_latch_a: assert property (@(posedge clk) disable iff (rst)
		!puw_done |=> !$rose(st_r[`ST_WL]))
		else $error("write latch set during power-up delay");
	paused_quiet_a: assert property (@(posedge clk) disable iff (rst)
		paused_r |=> lane1_oe_n)
		else $error("output driven while paused");
	lock_guard_a: assert property (@(posedge clk) disable iff (rst)
		status_locked && !busy_r |=> $stable(st_r[`ST_GHI:`ST_GLO]))
		else $error("guard bits changed while locked");
	latch_needed_a: assert property (@(posedge clk) disable iff (rst)
		!st_r[`ST_WL] && !busy_r |=> !busy_r)
		else $error("busy without write latch");
	busy_end_a: assert property (@(posedge clk) disable iff (rst)
		$fell(busy_r) |-> !st_r[`ST_WL])
		else $error("write latch survives completion");
	pause_low_a: assert property (@(posedge clk) disable iff (rst)
		!cs_n_s && !sck_s && pause_want && !paused_r |=> paused_r)
		else $error("pause not started with clock low");
	// Pause release with the clock low takes effect at once
	pause_end_a: assert property (@(posedge clk) disable iff (rst)
		!cs_n_s && !sck_s && !pause_want && paused_r |=> !paused_r)
		else $error("pause not ended with clock low");
	// A frame always opens with an empty opcode shifter
	frame_start_a: assert property (@(posedge clk) disable iff (rst)
		cs_fall |-> phase_r == PH_OPCODE && bit_r == 3'h0)
		else $error("frame opened mid-instruction");
	// Read data only moves right after a falling serial clock
	out_edge_a: assert property (@(posedge clk) disable iff (rst)
		!cs_n_s && $changed(lane1_o) |-> $past(fall))
		else $error("lane 1 changed away from a falling clock");
	// Nothing modifying may start inside the power-up delay
	puw_busy_a: assert property (@(posedge clk) disable iff (rst)
		!puw_done |=> !$rose(busy_r))
		else $error("modify accepted during power-up delay");
	// Guarded array refuses program and erase
	region_block_a: assert property (@(posedge clk) disable iff (rst)
		cs_rise && is_mod && region_prot |=> !$rose(busy_r))
		else $error("program or erase ran in a guarded region");
	// Power-down leaves state alone for all but release
	pd_ignore_a: assert property (@(posedge clk) disable iff (rst)
		pd_r && cs_rise && op_r != `OP_RPD |=> $stable(st_r) && pd_r)
		else $error("instruction acted on in power-down");
	// A frame cut off a byte boundary changes nothing
	odd_end_a: assert property (@(posedge clk) disable iff (rst)
		cs_rise && !on_byte && !busy_r |=> $stable(st_r) && !$rose(busy_r))
		else $error("instruction acted on off a byte boundary");
endmodule

// ===== spi_master_model.sv
/*
 SPI bus master model facing the flash front end, modes 0 and 3.
 Assumes clk is the bench clock; sck phases are counted in clk cycles.
*/
`timescale 1ns/1ns
module spi_master_model (
	input wire logic clk, // Bench clock
	input wire logic lane1, // Lane 1 wire level
	input wire logic lane1_oe_n, // Device lane 1 enable
	output logic sck, // Serial clock
	output logic cs_n, // Select, active low
	output logic pause_n, // Pause, active low
	output logic lane0 // Lane 0 wire level
);
	localparam int LO = 7; // Low phase, leaves room for output change
	localparam int HI = 6; // High phase
	logic mode3; // Idle clock level
	logic paused_oe; // Lane 1 enable seen while paused
	logic bit_r; // Bit on lane 0
	logic tog; // Changes every cycle
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		pause_n = 1'b1;
		mode3 = 1'b0;
		paused_oe = 1'b1;
		bit_r = 1'b0;
		tog = 1'b0;
	end
	always @(posedge clk) tog <= ~tog;
	// Released lane toggles every cycle, so it does not hold the last bit
	assign lane0 = cs_n ? tog : bit_r;
	////////////////////////////////////////////////////////////////
	// One frame: nbits msb first, pause before bit pause_at
	task automatic xfer(input logic [39:0] tx, input int nbits, input int pause_at, output logic [7:0] rx);
		rx = 8'h00;
		sck <= mode3;
		repeat (2) @(posedge clk);
		cs_n <= 1'b0;
		repeat (LO) @(posedge clk);
		for (int i = 0; i < nbits; i++) begin
			sck <= 1'b0;
			bit_r <= tx[39 - i];
			repeat (LO) @(posedge clk);
			if (i == pause_at) begin
				pause_n <= 1'b0;
				repeat (LO) @(posedge clk);
				// Clock and data wiggle while paused, must be ignored
				repeat (2) begin
					sck <= 1'b1;
					bit_r <= tog;
					repeat (HI) @(posedge clk);
					paused_oe <= lane1_oe_n;
					sck <= 1'b0;
					repeat (LO) @(posedge clk);
				end
				pause_n <= 1'b1;
				bit_r <= tx[39 - i];
				repeat (LO) @(posedge clk);
			end
			sck <= 1'b1;
			rx = {rx[6:0], lane1};
			repeat (HI) @(posedge clk);
		end
		if (!mode3) begin
			sck <= 1'b0;
			repeat (LO) @(posedge clk);
		end
		cs_n <= 1'b1;
		repeat (12) @(posedge clk);
	endtask
endmodule

// ===== tb_flash_spi_guard.sv
/*
 Self-checking bench for the flash front end, driven by the master model.
 Assumes the design's defines header is on the include path.
*/
`timescale 1ns/1ns
`include "flash_guard_defines.svh"
module tb_flash_spi_guard;
	localparam int PUW = 400; // Shortened power-up write delay
	logic clk = 1'b0; // Bench clock
	logic rst = 1'b1; // Power-on reset
	logic guard_n = 1'b1; // Write guard pin
	logic sck, cs_n, pause_n, lane0; // Master side pins
	logic lane0_o, lane0_oe_n, lane1_o, lane1_oe_n, powered_down; // Design outputs
	logic [7:0] status_out; // Status image
	logic lane1_last = 1'b0; // Last driven lane 1 level
	logic lane1; // Lane 1 wire
	logic [7:0] rx; // Bits read back
	int err_count = 0; // Mismatches
	int comparisons = 0; // Checks made
	int cycles = 0; // Hang guard
	always #5 clk = ~clk;
	// Undriven lane shows the inverse, so a stale bit cannot pass
	always @(posedge clk) if (!lane1_oe_n) lane1_last <= lane1_o;
	assign lane1 = lane1_oe_n ? ~lane1_last : lane1_o;
	flash_spi_guard #(.PUW_CYCLES(PUW)) uut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .pause_n(pause_n),
		.guard_n(guard_n), .lane0_i(lane0), .lane0_o(lane0_o), .lane0_oe_n(lane0_oe_n), .lane1_i(lane1),
		.lane1_o(lane1_o), .lane1_oe_n(lane1_oe_n), .status_out(status_out), .powered_down(powered_down));
	spi_master_model m (.clk(clk), .lane1(lane1), .lane1_oe_n(lane1_oe_n), .sck(sck), .cs_n(cs_n),
		.pause_n(pause_n), .lane0(lane0));
	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		m.xfer({op, 32'h0}, 8, -1, rx);
	endtask
	task automatic wrsr(input logic [7:0] v, input int nbits);
		m.xfer({`OP_WRSR, v, 24'h0}, nbits, -1, rx);
	endtask
	// Status settles a few cycles after select rises
	task automatic st(input logic [7:0] exp);
		repeat (10) @(posedge clk);
		check("status", status_out, exp);
	endtask
	task automatic rdsr(input logic [7:0] exp, input int pause_at);
		m.xfer({`OP_RDSR, 32'h0}, 16, pause_at, rx);
		check("lane1", rx, exp);
	endtask
	task automatic give_verdict;
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			give_verdict;
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("reset", status_out, `STATUS_RESET);
		check("oe", {6'h0, lane0_oe_n, lane1_oe_n}, 8'h03);
		cmd(`OP_WREN);
		st(8'h00);
		repeat (PUW) @(posedge clk);
		wrsr(8'hFF, 16);
		st(8'h00);
		cmd(`OP_WREN);
		st(8'h02);
		rdsr(8'h02, -1);
		cmd(`OP_WRDI);
		st(8'h00);
		m.mode3 = 1'b1;
		cmd(`OP_WREN);
		rdsr(8'h02, -1);
		m.mode3 = 1'b0;
		wrsr(8'hFF, 12);
		st(8'h02);
		wrsr(8'hFF, 16);
		cmd(`OP_WREN);
		m.xfer({`OP_RDSR, 32'h0}, 16, -1, rx);
		check("busy", {7'h0, rx[0]}, 8'h01);
		repeat (1100) @(posedge clk);
		st(8'hAC);
		guard_n <= 1'b0;
		cmd(`OP_WREN);
		wrsr(8'h00, 16);
		repeat (1100) @(posedge clk);
		st(8'hAC);
		guard_n <= 1'b1;
		cmd(`OP_WREN);
		m.xfer({`OP_PROG, 24'h0, 8'h55}, 40, -1, rx);
		st(8'hAE);
		cmd(`OP_WREN);
		wrsr(8'h00, 16);
		repeat (1100) @(posedge clk);
		st(8'h00);
		cmd(`OP_PD);
		check("pd", {7'h0, powered_down}, 8'h01);
		cmd(`OP_WREN);
		st(8'h00);
		cmd(`OP_RPD);
		check("pd", {7'h0, powered_down}, 8'h00);
		cmd(`OP_WREN);
		rdsr(8'h02, 11);
		check("pause_oe", {7'h0, m.paused_oe}, 8'h01);
		// Second power-on reset: latch is lost and the write delay starts over
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("reset2", status_out, `STATUS_RESET);
		cmd(`OP_WREN);
		st(8'h00);
		give_verdict;
	end
endmodule
